// ---- jls_pkg.sv ----
// Purpose: shared constants for the link status and test block
// Assumes: 32-bit apb data, word-aligned registers
// Notes:   offsets are byte addresses
package jls_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_FRM  = 3;
  localparam int NUM_LANE = 4;
  localparam int LANE_W   = 16;
  localparam int NUM_DAC  = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int STAT_W   = 8;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_LINK_CTRL  = 12'h000;
  localparam logic [11:0] OFF_TEST_CFG   = 12'h004;
  localparam logic [11:0] OFF_INJECT     = 12'h008;
  localparam logic [11:0] OFF_STAT_SEL   = 12'h00c;
  localparam logic [11:0] OFF_STATUS     = 12'h010;
  localparam logic [11:0] OFF_PATTERN    = 12'h014;
  localparam logic [11:0] OFF_LINK_CFG   = 12'h018;
  localparam logic [11:0] OFF_LANE_MAP   = 12'h01c;
  localparam logic [11:0] OFF_PRBS_CTRL  = 12'h020;
  localparam logic [11:0] OFF_PRBS_ERR0  = 12'h024;
  localparam logic [11:0] OFF_PRBS_ERR1  = 12'h028;
  localparam logic [11:0] OFF_XBAR       = 12'h02c;
  localparam logic [11:0] OFF_LANE_OWNER = 12'h030;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ST_SYNC = 3;
  localparam int ST_PERR = 2;
  localparam int ST_PEST = 1;
  localparam int ST_UNSUP = 0;
  localparam int EN_BIT  = 8;
  localparam int SRC_LSB = 12;
  localparam int PT_LSB  = 16;
  localparam int CFG_L_LSB = 8;
  localparam int SEL0_LSB = 4;
  localparam int SEL1_LSB = 6;
  // ----------------------------------------------------------------
  // reset values and fixed patterns
  // ----------------------------------------------------------------
  localparam logic [7:0]  LANE_MAP_RST = 8'he4;
  localparam logic [23:0] XBAR_RST     = 24'hfac688;
  localparam logic [31:0] LINK_CFG_RST = 32'h0000_0404;
  localparam logic [15:0] CHECKER_WORD = 16'haaaa;
  localparam logic [15:0] TOGGLE_WORD  = 16'hffff;
  localparam logic [30:0] LFSR_SEED    = 31'h7fffffff;
  // ----------------------------------------------------------------
  // test sources and insertion points
  // ----------------------------------------------------------------
  localparam logic [3:0] NORMAL_SAMPLE_SOURCE         = 4'h0;
  localparam logic [3:0] SRC_CHECKER                  = 4'h1;
  localparam logic [3:0] SRC_TOGGLE                   = 4'h2;
  localparam logic [3:0] SRC_PRBS31                   = 4'h3;
  localparam logic [3:0] SRC_PRBS23                   = 4'h4;
  localparam logic [3:0] SRC_PRBS15                   = 4'h5;
  localparam logic [3:0] SRC_PRBS9                    = 4'h6;
  localparam logic [3:0] SRC_PRBS7                    = 4'h7;
  localparam logic [3:0] SRC_RAMP                     = 4'h8;
  localparam logic [3:0] PROGRAMMED_PATTERN_REPEATING = 4'h9;
  localparam logic [3:0] PROGRAMMED_PATTERN_SINGLE    = 4'ha;
  localparam logic [1:0] INSERT_AT_FRAMER_INPUT       = 2'h0;
  localparam logic [1:0] INSERT_AT_SERIALIZER         = 2'h1;
  localparam logic [1:0] INSERT_AFTER_LANE_MAPPING    = 2'h2;
endpackage

// ---- jls_fifo.sv ----
// Purpose: lane word buffer with valid/ready on both sides
// Assumes: one clock, push and pop in the same cycle allowed
// Notes:   in_ready is registered
module jls_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];
  assign cnt_d     = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q     <= '0;
      rd_q     <= '0;
      cnt_q    <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q    <= cnt_d;
      in_ready <= (cnt_d != (AW+1)'(DEPTH));
    end
  end

  chk_fifo_no_overflow: assert property (@(posedge clk) disable iff (!rst_n)
    in_ready |-> cnt_q < (AW+1)'(DEPTH))
    else $error("fifo ready while full");
endmodule

// ---- jls_prbs_chk.sv ----
// Purpose: self-synchronising prbs7 checker with saturating error count
// Assumes: msb of each word is the earliest bit
// Notes:   first word only seeds the history
module jls_prbs_chk #(
  parameter int W  = 16,
  parameter int CW = 32
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          restart,
  input  wire logic          enable,
  input  wire logic          valid,
  input  wire logic [W-1:0]  data,
  output logic      [CW-1:0] err_cnt
);
  logic [6:0]  hist_q;
  logic        seeded_q;
  logic [6:0]  hist_d;
  logic [5:0]  errs;
  logic [CW:0] sum;

  always_comb begin
    hist_d = hist_q;
    errs   = '0;
    for (int i = W - 1; i >= 0; i--) begin
      if ((hist_d[6] ^ hist_d[5]) != data[i]) begin
        errs = errs + 6'h01;
      end
      hist_d = {hist_d[5:0], data[i]};
    end
    sum = {1'b0, err_cnt} + (CW+1)'(errs);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hist_q   <= '0;
      seeded_q <= 1'b0;
      err_cnt  <= '0;
    end else if (restart) begin
      seeded_q <= 1'b0;
      err_cnt  <= '0;
    end else if (enable && valid) begin
      hist_q   <= hist_d;
      seeded_q <= 1'b1;
      if (seeded_q) begin
        err_cnt <= sum[CW] ? '1 : sum[CW-1:0];
      end
    end
  end

  chk_count_saturates: assert property (@(posedge clk) disable iff (!rst_n)
    (err_cnt == '1) && !restart |=> err_cnt == '1)
    else $error("error count wrapped");
endmodule

// ---- jls_top.sv ----
// Purpose: framer status/test logic and deframer lane path behind apb
// Assumes: lane and sample data come from logic on pclk
// Notes:   sync and sysref pins are synchronised
module jls_top #(
  parameter int LMFC_PERIOD = 32
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic      [31:0]  prdata,
  output logic              pslverr,
  input  wire logic [2:0]   sync_request_input,
  input  wire logic         sysref_in,
  input  wire logic [191:0] adc_lane_data,
  output logic      [191:0] frm_lane_data,
  input  wire logic         lane_in_valid,
  output logic              lane_in_ready,
  input  wire logic [63:0]  lane_in_data,
  input  wire logic         dac_ready,
  output logic              dac_valid,
  output logic      [127:0] dac_data
);
  localparam int NF = jls_pkg::NUM_FRM;
  localparam int NL = jls_pkg::NUM_LANE;
  localparam int LW = jls_pkg::LANE_W;
  localparam int CW = $clog2(LMFC_PERIOD);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [30:0] prbs_adv(input logic [30:0] s, input int n, input int k);
    logic [30:0] r;
    r = s;
    for (int i = 0; i < LW; i++) begin
      r = {r[29:0], r[n-1] ^ r[k-1]};
    end
    return r;
  endfunction

  function automatic logic [LW-1:0] lane_of(input logic [63:0] w, input logic [1:0] idx);
    return w[idx*LW +: LW];
  endfunction

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  logic [3:0] pin_m_q;
  logic [3:0] pin_s_q;
  logic       sysref_d_q;
  logic [2:0] sync_s;
  logic       sysref_edge;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_m_q    <= '0;
      pin_s_q    <= '0;
      sysref_d_q <= 1'b0;
    end else begin
      pin_m_q    <= {sysref_in, sync_request_input};
      pin_s_q    <= pin_m_q;
      sysref_d_q <= pin_s_q[3];
    end
  end
  assign sync_s      = pin_s_q[2:0];
  assign sysref_edge = pin_s_q[3] & ~sysref_d_q;

  // ------------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------------
  logic        setup;
  logic        wr_acc;
  logic [31:0] rd_d;
  logic        hit_d;

  assign setup  = psel & ~penable;
  assign wr_acc = psel & penable & pready & pwrite & ~pslverr;

  logic [NF-1:0]      en_q;
  logic [NF-1:0]      test_en_q;
  logic [3:0]         src_q [NF];
  logic [1:0]         pt_q [NF];
  logic [NL-1:0]      inj_q [NF];
  logic [NF-1:0]      pest_q;
  logic [NF-1:0]      perr_q;
  logic [CW-1:0]      lmfc_q [NF];
  logic [1:0]         choice_q;
  logic [15:0]        pattern_q;
  logic [31:0]        cfg_q;
  logic [7:0]         lane_map_q;
  logic [7:0]         prbs_ctrl_q;
  logic [23:0]        xbar_q;
  logic [NL-1:0]      owner_q;
  logic [31:0]        err_cnt [2];
  logic               unsup;
  logic [7:0]         stat_w [NF];

  // m in 1,2,4,8 and l in 1,2,4
  always_comb begin
    unsup = 1'b1;
    if ((cfg_q[3:0] inside {4'h1, 4'h2, 4'h4, 4'h8}) &&
        (cfg_q[jls_pkg::CFG_L_LSB +: 3] inside {3'h1, 3'h2, 3'h4})) begin
      unsup = 1'b0;
    end
  end

  always_comb begin
    for (int f = 0; f < NF; f++) begin
      stat_w[f] = '0;
      stat_w[f][jls_pkg::ST_SYNC]  = sync_s[f];
      stat_w[f][jls_pkg::ST_PERR]  = perr_q[f];
      stat_w[f][jls_pkg::ST_PEST]  = pest_q[f];
      stat_w[f][jls_pkg::ST_UNSUP] = unsup;
    end
  end

  always_comb begin
    rd_d  = '0;
    hit_d = 1'b1;
    case (paddr)
      jls_pkg::OFF_LINK_CTRL:  rd_d = {29'h0, en_q};
      jls_pkg::OFF_TEST_CFG:   rd_d = {14'h0, pt_q[choice_q], src_q[choice_q], 3'h0, test_en_q[choice_q], 8'h0};
      jls_pkg::OFF_INJECT:     rd_d = {28'h0, inj_q[choice_q]};
      jls_pkg::OFF_STAT_SEL:   rd_d = {30'h0, choice_q};
      jls_pkg::OFF_STATUS:     rd_d = {24'h0, stat_w[choice_q]};
      jls_pkg::OFF_PATTERN:    rd_d = {16'h0, pattern_q};
      jls_pkg::OFF_LINK_CFG:   rd_d = cfg_q;
      jls_pkg::OFF_LANE_MAP:   rd_d = {24'h0, lane_map_q};
      jls_pkg::OFF_PRBS_CTRL:  rd_d = {24'h0, prbs_ctrl_q};
      jls_pkg::OFF_PRBS_ERR0:  rd_d = err_cnt[0];
      jls_pkg::OFF_PRBS_ERR1:  rd_d = err_cnt[1];
      jls_pkg::OFF_XBAR:       rd_d = {8'h0, xbar_q};
      jls_pkg::OFF_LANE_OWNER: rd_d = {28'h0, owner_q};
      default:                 hit_d = 1'b0;
    endcase
    if (choice_q == 2'h3) begin
      hit_d = hit_d & (paddr != jls_pkg::OFF_STATUS);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit_d;
      if (setup) begin
        prdata <= hit_d ? rd_d : '0;
      end
    end
  end

  // ------------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      choice_q    <= '0;
      pattern_q   <= '0;
      cfg_q       <= jls_pkg::LINK_CFG_RST;
      lane_map_q  <= jls_pkg::LANE_MAP_RST;
      prbs_ctrl_q <= '0;
      xbar_q      <= jls_pkg::XBAR_RST;
      owner_q     <= '0;
    end else if (wr_acc) begin
      case (paddr)
        jls_pkg::OFF_STAT_SEL:   choice_q    <= pwdata[1:0];
        jls_pkg::OFF_PATTERN:    pattern_q   <= pwdata[15:0];
        jls_pkg::OFF_LINK_CFG:   cfg_q       <= pwdata;
        jls_pkg::OFF_LANE_MAP:   lane_map_q  <= pwdata[7:0];
        jls_pkg::OFF_PRBS_CTRL:  prbs_ctrl_q <= pwdata[7:0];
        jls_pkg::OFF_XBAR:       xbar_q      <= pwdata[23:0];
        jls_pkg::OFF_LANE_OWNER: owner_q     <= pwdata[NL-1:0];
        default:                 ;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // framer state: enable, test config, sysref phase
  // ------------------------------------------------------------------
  logic [NL-1:0] inj_used;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q      <= '0;
      test_en_q <= '0;
      pest_q    <= '0;
      perr_q    <= '0;
      for (int f = 0; f < NF; f++) begin
        src_q[f]  <= jls_pkg::NORMAL_SAMPLE_SOURCE;
        pt_q[f]   <= jls_pkg::INSERT_AT_FRAMER_INPUT;
        inj_q[f]  <= '0;
        lmfc_q[f] <= '0;
      end
    end else begin
      for (int f = 0; f < NF; f++) begin
        if (wr_acc && paddr == jls_pkg::OFF_LINK_CTRL && pwdata[f]) begin
          en_q[f] <= pwdata[jls_pkg::EN_BIT];
        end
        if (wr_acc && paddr == jls_pkg::OFF_TEST_CFG && pwdata[f]) begin
          test_en_q[f] <= pwdata[jls_pkg::EN_BIT];
          src_q[f]     <= pwdata[jls_pkg::SRC_LSB +: 4];
          pt_q[f]      <= pwdata[jls_pkg::PT_LSB +: 2];
        end
        if (wr_acc && paddr == jls_pkg::OFF_INJECT && pwdata[9:8] == 2'(f) && test_en_q[f]) begin
          inj_q[f] <= pwdata[NL-1:0];
        end else if (inj_q[f] != '0) begin
          inj_q[f] <= '0;
        end
        lmfc_q[f] <= (lmfc_q[f] == CW'(LMFC_PERIOD - 1)) ? '0 : lmfc_q[f] + 1'b1;
        if (!en_q[f]) begin
          pest_q[f] <= 1'b0;
          perr_q[f] <= 1'b0;
        end else if (sysref_edge) begin
          if (!pest_q[f]) begin
            pest_q[f] <= 1'b1;
            lmfc_q[f] <= CW'(1);
          end else if (lmfc_q[f] != '0) begin
            perr_q[f] <= 1'b1;
          end
        end
      end
    end
  end
  assign inj_used = inj_q[0];

  chk_phase_err_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    perr_q[0] && en_q[0] |=> perr_q[0])
    else $error("phase error dropped while enabled");
  chk_error_needs_phase: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(perr_q[0]) |-> $past(pest_q[0]) && $past(sysref_edge))
    else $error("phase error without established phase");
  chk_disable_clears: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == jls_pkg::OFF_LINK_CTRL && pwdata[0] && !pwdata[jls_pkg::EN_BIT]
    |=> !en_q[0] ##1 !pest_q[0] && !perr_q[0])
    else $error("framer not disabled");
  chk_inject_in_test: assert property (@(posedge pclk) disable iff (!presetn)
    inj_used != '0 |-> test_en_q[0])
    else $error("injection outside test mode");

  // ------------------------------------------------------------------
  // test pattern generators and framer lane output
  // ------------------------------------------------------------------
  logic [30:0]   lfsr_q [NF];
  logic [LW-1:0] ramp_q [NF];
  logic [NF-1:0] tog_q;
  logic [NF-1:0] once_q;
  logic [LW-1:0] tw [NF];
  logic [30:0]   lf_next [NF];

  always_comb begin
    for (int f = 0; f < NF; f++) begin
      case (src_q[f])
        jls_pkg::SRC_PRBS31: lf_next[f] = prbs_adv(lfsr_q[f], 31, 28);
        jls_pkg::SRC_PRBS23: lf_next[f] = prbs_adv(lfsr_q[f], 23, 18);
        jls_pkg::SRC_PRBS15: lf_next[f] = prbs_adv(lfsr_q[f], 15, 14);
        jls_pkg::SRC_PRBS9:  lf_next[f] = prbs_adv(lfsr_q[f], 9, 5);
        default:             lf_next[f] = prbs_adv(lfsr_q[f], 7, 6);
      endcase
      case (src_q[f])
        jls_pkg::SRC_CHECKER:                  tw[f] = jls_pkg::CHECKER_WORD;
        jls_pkg::SRC_TOGGLE:                   tw[f] = tog_q[f] ? jls_pkg::TOGGLE_WORD : '0;
        jls_pkg::SRC_RAMP:                     tw[f] = ramp_q[f];
        jls_pkg::PROGRAMMED_PATTERN_REPEATING: tw[f] = pattern_q;
        jls_pkg::PROGRAMMED_PATTERN_SINGLE:    tw[f] = once_q[f] ? '0 : pattern_q;
        default:                               tw[f] = lf_next[f][LW-1:0];
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tog_q  <= '0;
      once_q <= '0;
      for (int f = 0; f < NF; f++) begin
        lfsr_q[f] <= jls_pkg::LFSR_SEED;
        ramp_q[f] <= '0;
      end
    end else begin
      for (int f = 0; f < NF; f++) begin
        if (test_en_q[f] && en_q[f]) begin
          lfsr_q[f] <= lf_next[f];
          ramp_q[f] <= ramp_q[f] + 1'b1;
          tog_q[f]  <= ~tog_q[f];
          once_q[f] <= 1'b1;
        end else begin
          lfsr_q[f] <= jls_pkg::LFSR_SEED;
          ramp_q[f] <= '0;
          tog_q[f]  <= 1'b0;
          once_q[f] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frm_lane_data <= '0;
    end else begin
      for (int f = 0; f < NF; f++) begin
        for (int j = 0; j < NL; j++) begin
          logic [63:0]   smp;
          logic [LW-1:0] w;
          smp = adc_lane_data[f*64 +: 64];
          w   = lane_of(smp, lane_map_q[j*2 +: 2]);
          if (test_en_q[f] && src_q[f] != jls_pkg::NORMAL_SAMPLE_SOURCE) begin
            w = tw[f];
            if (inj_q[f][j]) begin
              w = ~w;
            end
          end
          frm_lane_data[(f*NL+j)*LW +: LW] <= en_q[f] ? w : '0;
        end
      end
    end
  end

  chk_checker_on_lanes: assert property (@(posedge pclk) disable iff (!presetn)
    en_q[0] && test_en_q[0] && src_q[0] == jls_pkg::SRC_CHECKER && inj_q[0] == '0
    |=> frm_lane_data[LW-1:0] == jls_pkg::CHECKER_WORD)
    else $error("test word not on lane");
  chk_status_layout: assert property (@(posedge pclk) disable iff (!presetn)
    setup && paddr == jls_pkg::OFF_STATUS && choice_q == 2'h1
    |=> prdata[31:4] == '0 && prdata[jls_pkg::ST_SYNC] == $past(sync_s[1]))
    else $error("status word layout wrong");

  // ------------------------------------------------------------------
  // deframer: lane buffer, sample crossbar, prbs check
  // ------------------------------------------------------------------
  logic        fifo_valid;
  logic [63:0] fifo_data;
  logic        pop;
  logic [LW-1:0] stream [jls_pkg::NUM_DAC];
  logic        restart;

  jls_fifo #(
    .WIDTH (64),
    .DEPTH (jls_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (pclk),
    .rst_n     (presetn),
    .in_valid  (lane_in_valid),
    .in_ready  (lane_in_ready),
    .in_data   (lane_in_data),
    .out_valid (fifo_valid),
    .out_ready (dac_ready),
    .out_data  (fifo_data)
  );
  assign pop = fifo_valid & dac_ready;

  always_comb begin
    for (int i = 0; i < NL; i++) begin
      stream[i]      = owner_q[i] ? '0 : fifo_data[i*LW +: LW];
      stream[i + NL] = owner_q[i] ? fifo_data[i*LW +: LW] : '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_valid <= 1'b0;
      dac_data  <= '0;
    end else begin
      dac_valid <= pop;
      if (pop) begin
        for (int d = 0; d < jls_pkg::NUM_DAC; d++) begin
          dac_data[d*LW +: LW] <= stream[xbar_q[d*3 +: 3]];
        end
      end
    end
  end

  chk_xbar_route: assert property (@(posedge pclk) disable iff (!presetn)
    pop && xbar_q[2:0] == 3'h5 && owner_q[1] |=> dac_data[LW-1:0] == $past(fifo_data[2*LW-1:LW]))
    else $error("crossbar routed wrong stream");

  assign restart = wr_acc && paddr == jls_pkg::OFF_PRBS_CTRL;

  for (genvar d = 0; d < 2; d++) begin : g_chk
    logic [1:0] sel;
    assign sel = prbs_ctrl_q[(d == 0 ? jls_pkg::SEL0_LSB : jls_pkg::SEL1_LSB) +: 2];
    jls_prbs_chk #(
      .W  (LW),
      .CW (32)
    ) u_chk (
      .clk     (pclk),
      .rst_n   (presetn),
      .restart (restart),
      .enable  (prbs_ctrl_q[d]),
      .valid   (pop && owner_q[sel] == 1'(d)),
      .data    (lane_of(fifo_data, sel)),
      .err_cnt (err_cnt[d])
    );
  end
endmodule

// ---- jls_bb_model.sv ----
// Purpose: baseband side that pushes lane words into the deframer
// Assumes: one word carries all four lanes
// Notes:   sends 33 counting words on start, holds each until taken
module jls_bb_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic        ready,
  output logic             valid,
  output logic      [63:0] data
);
  logic [5:0] left_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid <= 1'b0;
      left_q <= 6'h00;
      data <= 64'h0;
    end else if (start) begin
      valid <= 1'b1;
      left_q <= 6'h21;
      data <= {4{16'h0001}};
    end else if (valid && ready) begin
      // every lane steps together on one word clock
      valid <= (left_q > 6'h01);
      left_q <= left_q - 6'h01;
      data <= (left_q > 6'h01) ? {4{data[15:0] + 16'h0001}} : ~data;
    end else if (!valid) begin
      // released bus shows a moving pattern
      data <= ~data;
    end
  end
endmodule

// ---- jesd_link_status_and_test_test.sv ----
// Purpose: self-checking bench for the link status and test block
// Assumes: apb answers after one access cycle
// Notes:   lane traffic comes from jls_bb_model
module jesd_link_status_and_test_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic         lane_in_valid, lane_in_ready, dac_ready, dac_valid, start, sysref;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic [2:0]   sync_request_input;
  logic [191:0] frm_lane_data;
  logic [63:0]  lane_in_data;
  logic [127:0] dac_data;
  int           errors, checks_done, n;
  localparam logic [191:0] ADC = {12{16'h0c3a}};
  jls_top #(.LMFC_PERIOD(8)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sync_request_input(sync_request_input), .sysref_in(sysref), .adc_lane_data(ADC),
    .frm_lane_data(frm_lane_data), .lane_in_valid(lane_in_valid), .lane_in_ready(lane_in_ready),
    .lane_in_data(lane_in_data), .dac_ready(dac_ready), .dac_valid(dac_valid), .dac_data(dac_data));
  jls_bb_model BB (.pclk(pclk), .presetn(presetn), .start(start), .ready(lane_in_ready),
    .valid(lane_in_valid), .data(lane_in_data));
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_status();
    apb(1, jls_pkg::OFF_STAT_SEL, 32'h1);
    apb(0, jls_pkg::OFF_STATUS, 0);
    chk("status1", rd, 32'h8);
    apb(1, jls_pkg::OFF_LINK_CFG, 32'h403);
    apb(0, jls_pkg::OFF_STATUS, 0);
    chk("unsup", rd, 32'h9);
    apb(1, jls_pkg::OFF_STAT_SEL, 32'h0);
    apb(0, jls_pkg::OFF_STATUS, 0);
    chk("status0", rd, 32'h1);
    apb(1, jls_pkg::OFF_LINK_CFG, 32'h404);
    apb(1, jls_pkg::OFF_STAT_SEL, 32'h3);
    apb(0, jls_pkg::OFF_STATUS, 0);
    chk("choice3", e, 1);
    apb(0, 12'h0fc, 0);
    chk("unmapped", {e, rd[0]}, 2'b10);
  endtask
  task automatic t_sysref();
    apb(1, jls_pkg::OFF_LINK_CTRL, 32'h101);
    apb(1, jls_pkg::OFF_STAT_SEL, 32'h0);
    repeat (2) begin
      sysref <= 1'b1;
      repeat (4) @(posedge pclk);
      sysref <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    apb(0, jls_pkg::OFF_STATUS, 0);
    chk("phase_est", rd, 32'h2);
    sysref <= 1'b1;
    repeat (4) @(posedge pclk);
    sysref <= 1'b0;
    repeat (20) @(posedge pclk);
    apb(0, jls_pkg::OFF_STATUS, 0);
    chk("phase_err", rd, 32'h6);
    apb(1, jls_pkg::OFF_LINK_CTRL, 32'h1);
    apb(1, jls_pkg::OFF_LINK_CTRL, 32'h101);
    apb(0, jls_pkg::OFF_STATUS, 0);
    chk("relink", rd, 32'h0);
  endtask
  task automatic t_framer();
    apb(1, jls_pkg::OFF_LINK_CTRL, 32'h101);
    apb(0, jls_pkg::OFF_LINK_CTRL, 0);
    chk("enable", rd, 32'h1);
    apb(1, jls_pkg::OFF_PATTERN, 32'h1234);
    for (int s = 10; s >= 0; s--) begin
      apb(1, jls_pkg::OFF_TEST_CFG, 32'h101 | (s << 12));
      repeat (3) @(posedge pclk);
      if (s == 10) chk("once", frm_lane_data[31:0], 32'h0);
      if (s == 9) chk("pattern", frm_lane_data[31:0], 32'h12341234);
      if (s == 1) chk("checker", frm_lane_data[31:0], 32'haaaaaaaa);
      if (s == 0) chk("normal", frm_lane_data[31:0], ADC[31:0]);
    end
    apb(1, jls_pkg::OFF_TEST_CFG, 32'h21101);
    apb(0, jls_pkg::OFF_TEST_CFG, 0);
    chk("test_cfg", rd, 32'h00021100);
    apb(1, jls_pkg::OFF_INJECT, 32'h2);
    n = 0;
    repeat (4) begin
      @(posedge pclk);
      if (frm_lane_data[31:0] === 32'h5555aaaa) n++;
    end
    chk("inject", n, 1);
    apb(1, jls_pkg::OFF_LINK_CTRL, 32'h1);
    apb(0, jls_pkg::OFF_LINK_CTRL, 0);
    chk("disable", rd, 32'h0);
  endtask
  task automatic t_fifo();
    apb(1, jls_pkg::OFF_PRBS_CTRL, 32'h1);
    apb(1, jls_pkg::OFF_LANE_OWNER, 32'h2);
    apb(1, jls_pkg::OFF_XBAR, 32'hd);
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    repeat (40) @(posedge pclk);
    chk("full", {lane_in_ready, lane_in_valid}, 2'b01);
    dac_ready <= 1'b1;
    n = 0;
    repeat (60) begin
      @(posedge pclk);
      if (dac_valid === 1'b1) begin
        if (n == 0) chk("xbar", dac_data[31:0], 32'h1);
        if (n == 0) chk("owner", dac_data[63:32], 32'h00010001);
        n++;
      end
    end
    chk("pops", n, 33);
    apb(0, jls_pkg::OFF_PRBS_ERR0, 0);
    chk("prbs", rd != 0, 1);
    apb(1, jls_pkg::OFF_PRBS_CTRL, 32'h1);
    apb(0, jls_pkg::OFF_PRBS_ERR0, 0);
    chk("clear", rd, 0);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, start, dac_ready, sysref} = '0;
    paddr = '0;
    pwdata = '0;
    sync_request_input = 3'b010;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_status();
    t_sysref();
    t_framer();
    t_fifo();
    finish_test();
  end
  initial begin
    repeat (5000) @(posedge pclk);
    errors++;
    finish_test();
  end
endmodule
